/* File: logic/awc_pkg.sv */
package awc_pkg;

	// Register word indices; the byte address on the AXI4-Lite bus is four times the index.
	localparam logic [7:0] AWC_IDX_LT_HI = 8'hc7; // Less-than limit high byte index.
	localparam logic [7:0] AWC_IDX_LT_LO = 8'hc6; // Less-than limit low byte index.
	localparam logic [7:0] AWC_IDX_GT_HI = 8'hc5; // Greater-than limit high byte index.
	localparam logic [7:0] AWC_IDX_GT_LO = 8'hc4; // Greater-than limit low byte index.
	localparam logic [7:0] AWC_IDX_CTRL = 8'hc8; // Converter control register index.
	localparam logic [7:0] AWC_IDX_IRQ_EN = 8'hc9; // Interrupt enable index.
	localparam logic [7:0] AWC_IDX_IRQ_CLR = 8'hca; // Interrupt clear index.
	localparam logic [7:0] AWC_IDX_RESULT = 8'hcb; // Last compared value index.

	// Field positions inside the converter control register.
	localparam int AWC_CTRL_FLAG_BIT = 0; // Window-compare flag.
	localparam int AWC_CTRL_DIFF_BIT = 1; // Differential mode select.

	// Reset values; greater-than limit resets to the top so no unsigned value exceeds it.
	localparam logic [7:0] AWC_RST_LT = 8'h00; // Less-than bytes after reset.
	localparam logic [7:0] AWC_RST_GT = 8'hff; // Greater-than bytes after reset.

	// AXI response codes.
	localparam logic [1:0] AWC_RESP_OKAY = 2'h0; // Normal completion.
	localparam logic [1:0] AWC_RESP_SLVERR = 2'h2; // Unmapped address.

	// Shortest legal spacing of conversion results in SAR clocks.
	localparam int AWC_MIN_CONV_SAR_CLKS = 18; // Least conversion length.

	// Conversion result from the converter path.
	typedef struct packed {
		logic eoc; // End-of-conversion strobe of the first converter.
		logic [15:0] data; // Result word (differential word when in that mode).
	} awc_result_s;

	// Whole block state.
	typedef struct packed {
		logic [7:0] lt_hi; // Less-than limit high byte.
		logic [7:0] lt_lo; // Less-than limit low byte.
		logic [7:0] gt_hi; // Greater-than limit high byte.
		logic [7:0] gt_lo; // Greater-than limit low byte.
		logic diff; // Differential mode.
		logic flag; // Window-compare flag.
		logic irq_en; // Interrupt enable.
		logic [15:0] last; // Last compared value.
		logic bvalid; // Write response pending.
		logic [1:0] bresp; // Write response code.
		logic rvalid; // Read data pending.
		logic [31:0] rdata; // Read data.
		logic [1:0] rresp; // Read response code.
	} awc_state_s;

endpackage : awc_pkg

/* File: logic/awc_window.sv */
// What this block does
// - Compare each new result against two limits.
// - Flag lives in control register, software readable.
// - Each limit built from high and low bytes.
// - Single-ended mode compares first converter result.
// - Differential mode compares combined differential word.
// - Evaluate at end of conversion; else unchanged.
// - Less-than above greater-than: flag inside window.
// - Less-than below greater-than: flag outside window.
// - Limit ordering alone selects inside or outside.
// - Differential mode compares signed two's complement.
// - Single-ended mode compares unsigned values.
// - Less-than high byte read-write, resets zero.
// - Less-than low byte read-write, resets zero.
// - Accept results at least one conversion apart.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module awc_window
	import awc_pkg::*;
(
	input wire logic core_clk, // System clock, 10 MHz.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire awc_pkg::awc_result_s result, // Result strobe and word.
	input wire logic [11:0] s_axi_awaddr, // Write byte address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [11:0] s_axi_araddr, // Read byte address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	output logic irq // Level interrupt request.
);
	import awc_pkg::*;

	awc_state_s st; // Registered state.
	awc_state_s next_st; // Next state.
	logic wr_go; // A write is taken this cycle.
	logic rd_go; // A read is taken this cycle.
	logic [15:0] lt_word; // Assembled less-than limit.
	logic [15:0] gt_word; // Assembled greater-than limit.
	logic below_lt; // Value strictly below less-than limit.
	logic above_gt; // Value strictly above greater-than limit.
	logic inside_mode; // Limits ordered for inside-window detection.
	logic hit; // Window condition met by the incoming value.
	logic [31:0] rd_word; // Decoded read value.
	logic rd_ok; // Read address is mapped.
	logic wr_ok; // Write address is mapped.
	logic [7:0] wr_idx; // Word index of the write address.
	logic [7:0] rd_idx; // Word index of the read address.
	logic wr_aligned; // Write address is word aligned and in range.
	logic rd_aligned; // Read address is word aligned and in range.
	logic wr_lane; // A mapped write carries its low byte lane.
	logic [7:0] wr_byte; // Byte that a register write stores.

	// Address and data are taken together, so the slave never holds half a write.
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !st.bvalid;
	assign rd_go = s_axi_arvalid && !st.rvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;

	// Registers sit one per word; the byte address is four times the index.
	// An address that is not word aligned, or that lies past the index range, maps to nothing.
	assign wr_idx = s_axi_awaddr[9:2];
	assign rd_idx = s_axi_araddr[9:2];
	assign wr_aligned = (s_axi_awaddr[1:0] == 2'b00) && (s_axi_awaddr[11:10] == 2'b00);
	assign rd_aligned = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr[11:10] == 2'b00);
	// Only the low byte lane carries register contents, so a write without it changes nothing.
	assign wr_lane = wr_go && wr_ok && s_axi_wstrb[0];
	assign wr_byte = s_axi_wdata[7:0];

	// Interrupt follows the flag whenever it is enabled.
	assign irq = st.flag && st.irq_en;

	// Limits are assembled from their byte pairs.
	assign lt_word = {st.lt_hi, st.lt_lo};
	assign gt_word = {st.gt_hi, st.gt_lo};

	// Compare signed or unsigned; one comparator pair serves both modes.
	always_comb begin
		if (st.diff) begin
			below_lt = $signed(result.data) < $signed(lt_word);
			above_gt = $signed(result.data) > $signed(gt_word);
			inside_mode = $signed(lt_word) > $signed(gt_word);
		end else begin
			below_lt = result.data < lt_word;
			above_gt = result.data > gt_word;
			inside_mode = lt_word > gt_word;
		end
	end

	// Inside window needs both conditions, outside needs either one.
	assign hit = inside_mode ? (below_lt && above_gt) : (below_lt || above_gt);

	// Read decode of the register map; unmapped addresses return an error.
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		case (rd_idx)
			AWC_IDX_LT_HI: rd_word = {24'h000000, st.lt_hi};
			AWC_IDX_LT_LO: rd_word = {24'h000000, st.lt_lo};
			AWC_IDX_GT_HI: rd_word = {24'h000000, st.gt_hi};
			AWC_IDX_GT_LO: rd_word = {24'h000000, st.gt_lo};
			AWC_IDX_CTRL: rd_word = {30'h0, st.diff, st.flag};
			AWC_IDX_IRQ_EN: rd_word = {31'h0, st.irq_en};
			AWC_IDX_IRQ_CLR: rd_word = 32'h0000_0000;
			AWC_IDX_RESULT: rd_word = {16'h0000, st.last};
			default: rd_ok = 1'b0;
		endcase
		// Misaligned reads answer like unmapped ones.
		if (!rd_aligned) begin
			rd_word = 32'h0000_0000;
			rd_ok = 1'b0;
		end
	end

	// Write targets that exist; the result register is read-only.
	always_comb begin
		case (wr_idx)
			AWC_IDX_LT_HI, AWC_IDX_LT_LO, AWC_IDX_GT_HI, AWC_IDX_GT_LO,
			AWC_IDX_CTRL, AWC_IDX_IRQ_EN, AWC_IDX_IRQ_CLR: wr_ok = wr_aligned;
			default: wr_ok = 1'b0;
		endcase
	end

	// Next-state logic for registers, flag and bus answers.
	always_comb begin
		next_st = st;
		// Software writes, low byte lane only.
		if (wr_lane) begin
			case (wr_idx)
				AWC_IDX_LT_HI: next_st.lt_hi = wr_byte;
				AWC_IDX_LT_LO: next_st.lt_lo = wr_byte;
				AWC_IDX_GT_HI: next_st.gt_hi = wr_byte;
				AWC_IDX_GT_LO: next_st.gt_lo = wr_byte;
				AWC_IDX_CTRL: begin
					next_st.diff = s_axi_wdata[AWC_CTRL_DIFF_BIT];
					// Writing one leaves the flag alone; only zero clears it.
					if (!s_axi_wdata[AWC_CTRL_FLAG_BIT]) begin
						next_st.flag = 1'b0;
					end
				end
				AWC_IDX_IRQ_EN: next_st.irq_en = s_axi_wdata[0];
				AWC_IDX_IRQ_CLR: begin
					if (s_axi_wdata[0]) begin
						next_st.flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// A strobe evaluates every result; it is one cycle, so any spacing above one is fine.
		if (result.eoc) begin
			next_st.last = result.data;
			if (hit) begin
				next_st.flag = 1'b1;
			end
		end
		// Write response.
		if (wr_go) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = wr_ok ? AWC_RESP_OKAY : AWC_RESP_SLVERR;
		end else if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// Read response.
		if (rd_go) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_word;
			next_st.rresp = rd_ok ? AWC_RESP_OKAY : AWC_RESP_SLVERR;
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// State register; reset values keep the flag quiet until limits are loaded.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.lt_hi <= AWC_RST_LT;
			st.lt_lo <= AWC_RST_LT;
			st.gt_hi <= AWC_RST_GT;
			st.gt_lo <= AWC_RST_GT;
		end else begin
			st <= next_st;
		end
	end

	// A matching strobe raises the flag on the next edge.
	property p_set;
		@(posedge core_clk) disable iff (!rst_b) (result.eoc && hit) |=> st.flag;
	endproperty
	a_set: assert property (p_set) else $error("flag not set by match");

	// Without a matching strobe the flag cannot rise, whatever is written.
	property p_only_match;
		@(posedge core_clk) disable iff (!rst_b) (!st.flag && !(result.eoc && hit)) |=> !st.flag;
	endproperty
	a_only_match: assert property (p_only_match) else $error("flag rose without match");

	// Flag holds unless a write went in.
	property p_sticky;
		@(posedge core_clk) disable iff (!rst_b) (st.flag && !wr_go) |=> st.flag;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped without write");

	// Inside mode needs both bounds.
	property p_inside;
		@(posedge core_clk) disable iff (!rst_b) (inside_mode && hit) |-> (below_lt && above_gt);
	endproperty
	a_inside: assert property (p_inside) else $error("inside match wrong");

	// Outside mode needs one bound.
	property p_outside;
		@(posedge core_clk) disable iff (!rst_b) (!inside_mode && (below_lt || above_gt)) |-> hit;
	endproperty
	a_outside: assert property (p_outside) else $error("outside match missed");

	// In differential mode a negative value lies below a non-negative limit.
	property p_signed;
		@(posedge core_clk) disable iff (!rst_b)
			(st.diff && result.data[15] && !lt_word[15]) |-> below_lt;
	endproperty
	a_signed: assert property (p_signed) else $error("signed compare wrong");

	// In single-ended mode a word with its top bit set never lies below a limit without it.
	property p_unsigned;
		@(posedge core_clk) disable iff (!rst_b)
			(!st.diff && result.data[15] && !lt_word[15]) |-> !below_lt;
	endproperty
	a_unsigned: assert property (p_unsigned) else $error("unsigned compare wrong");

	// Interrupt tracks enabled flag.
	property p_irq;
		@(posedge core_clk) disable iff (!rst_b) irq == (st.flag && st.irq_en);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	// A taken read answers one cycle later.
	property p_read;
		@(posedge core_clk) disable iff (!rst_b) rd_go |=> s_axi_rvalid;
	endproperty
	a_read: assert property (p_read) else $error("read not answered");

	// A cycle without a strobe or a write leaves the flag where it was.
	property p_quiet_flag;
		@(posedge core_clk) disable iff (!rst_b) (!result.eoc && !wr_go) |=> $stable(st.flag);
	endproperty
	a_quiet_flag: assert property (p_quiet_flag) else $error("flag moved on a quiet cycle");

	// Every strobe is taken, however closely it follows the one before.
	property p_capture;
		@(posedge core_clk) disable iff (!rst_b) result.eoc |=> (st.last == $past(result.data));
	endproperty
	a_capture: assert property (p_capture) else $error("result not captured");

	// The captured value changes only with a strobe.
	property p_capture_quiet;
		@(posedge core_clk) disable iff (!rst_b) !result.eoc |=> $stable(st.last);
	endproperty
	a_capture_quiet: assert property (p_capture_quiet) else $error("result changed without strobe");

	// In differential mode a non-negative value lies above a negative limit.
	property p_signed_above;
		@(posedge core_clk) disable iff (!rst_b) (st.diff && !result.data[15] && gt_word[15]) |-> above_gt;
	endproperty
	a_signed_above: assert property (p_signed_above) else $error("signed upper compare wrong");

	// In single-ended mode a word with its top bit set lies above a limit without it.
	property p_unsigned_above;
		@(posedge core_clk) disable iff (!rst_b) (!st.diff && result.data[15] && !gt_word[15]) |-> above_gt;
	endproperty
	a_unsigned_above: assert property (p_unsigned_above) else $error("unsigned upper compare wrong");

	// The limits left by reset can never be met, in either mode, so no flag rises before setup.
	property p_reset_quiet;
		@(posedge core_clk) disable iff (!rst_b)
			(lt_word == {AWC_RST_LT, AWC_RST_LT} && gt_word == {AWC_RST_GT, AWC_RST_GT}) |-> !hit;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("reset limits matched");

	// Writing zero to the flag bit clears it when no strobe competes in that cycle.
	property p_clear_zero;
		@(posedge core_clk) disable iff (!rst_b)
			(wr_lane && wr_idx == AWC_IDX_CTRL && !wr_byte[AWC_CTRL_FLAG_BIT] && !result.eoc) |=> !st.flag;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("flag not cleared by zero");

	// Writing one to the flag bit keeps a set flag, so a mode change cannot lose an event.
	property p_keep_one;
		@(posedge core_clk) disable iff (!rst_b)
			(wr_lane && wr_idx == AWC_IDX_CTRL && wr_byte[AWC_CTRL_FLAG_BIT] && st.flag) |=> st.flag;
	endproperty
	a_keep_one: assert property (p_keep_one) else $error("flag lost on write of one");

	// The clear register drops the flag when no strobe competes in that cycle.
	property p_clear_reg;
		@(posedge core_clk) disable iff (!rst_b)
			(wr_lane && wr_idx == AWC_IDX_IRQ_CLR && wr_byte[0] && !result.eoc) |=> !st.flag;
	endproperty
	a_clear_reg: assert property (p_clear_reg) else $error("flag not cleared by clear register");

	// Setting the mode bit selects the differential word.
	property p_diff_on;
		@(posedge core_clk) disable iff (!rst_b)
			(wr_lane && wr_idx == AWC_IDX_CTRL && wr_byte[AWC_CTRL_DIFF_BIT]) |=> st.diff;
	endproperty
	a_diff_on: assert property (p_diff_on) else $error("differential mode not taken");

	// Clearing the mode bit returns to the single-ended word.
	property p_diff_off;
		@(posedge core_clk) disable iff (!rst_b)
			(wr_lane && wr_idx == AWC_IDX_CTRL && !wr_byte[AWC_CTRL_DIFF_BIT]) |=> !st.diff;
	endproperty
	a_diff_off: assert property (p_diff_off) else $error("single-ended mode not taken");

	// The less-than high byte stores what software writes.
	property p_lt_hi;
		@(posedge core_clk) disable iff (!rst_b)
			(wr_lane && wr_idx == AWC_IDX_LT_HI) |=> (st.lt_hi == $past(wr_byte));
	endproperty
	a_lt_hi: assert property (p_lt_hi) else $error("less-than high byte not stored");

	// The less-than low byte stores what software writes.
	property p_lt_lo;
		@(posedge core_clk) disable iff (!rst_b)
			(wr_lane && wr_idx == AWC_IDX_LT_LO) |=> (st.lt_lo == $past(wr_byte));
	endproperty
	a_lt_lo: assert property (p_lt_lo) else $error("less-than low byte not stored");

	// The greater-than high byte stores what software writes.
	property p_gt_hi;
		@(posedge core_clk) disable iff (!rst_b)
			(wr_lane && wr_idx == AWC_IDX_GT_HI) |=> (st.gt_hi == $past(wr_byte));
	endproperty
	a_gt_hi: assert property (p_gt_hi) else $error("greater-than high byte not stored");

	// The greater-than low byte stores what software writes.
	property p_gt_lo;
		@(posedge core_clk) disable iff (!rst_b)
			(wr_lane && wr_idx == AWC_IDX_GT_LO) |=> (st.gt_lo == $past(wr_byte));
	endproperty
	a_gt_lo: assert property (p_gt_lo) else $error("greater-than low byte not stored");

	// An accepted write response is withdrawn on the next edge.
	property p_wr_done;
		@(posedge core_clk) disable iff (!rst_b) (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid;
	endproperty
	a_wr_done: assert property (p_wr_done) else $error("write response not withdrawn");

	// An accepted read response is withdrawn on the next edge.
	property p_rd_done;
		@(posedge core_clk) disable iff (!rst_b) (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid;
	endproperty
	a_rd_done: assert property (p_rd_done) else $error("read response not withdrawn");

	// A read of an unmapped word answers with an error and zero data.
	property p_unmapped;
		@(posedge core_clk) disable iff (!rst_b)
			(rd_go && !rd_ok) |=> (s_axi_rresp == AWC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered wrongly");

endmodule : awc_window

`default_nettype wire

/* File: tb/awc_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Result path of the first converter: start launches one conversion ending in a one-cycle strobe.
module awc_conv_model
	import awc_pkg::*;
(
	input wire logic core_clk, // System clock.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic start, // Launch one conversion.
	input wire logic [15:0] word, // Word the conversion produces.
	output var awc_pkg::awc_result_s result // Strobe and result word.
);
	import awc_pkg::*;
	int unsigned busy_cnt; // Cycles left in the running conversion.
	logic [15:0] held; // Word captured at start.
	// Each conversion lasts the shortest legal length; a new start waits for idle, so strobes come no closer than 19 cycles.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_cnt <= 0;
			held <= 16'h0000;
			result <= '0;
		end else begin
			result.eoc <= 1'b0;
			// Data outside the strobe toggles, so a late sample shows up as a wrong value.
			result.data <= ~result.data;
			if (start && busy_cnt == 0) begin
				busy_cnt <= AWC_MIN_CONV_SAR_CLKS;
				held <= word;
			end else if (busy_cnt == 1) begin
				busy_cnt <= 0;
				result.eoc <= 1'b1;
				result.data <= held;
			end else if (busy_cnt != 0) begin
				busy_cnt <= busy_cnt - 1;
			end
		end
	end
endmodule : awc_conv_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// Register traffic over AXI4-Lite and conversions from the model, checked against expected values.
module tb;
	import awc_pkg::*;
	typedef struct packed {logic diff; logic [15:0] lt; logic [15:0] gt; logic [15:0] data; logic hit;} awc_case_s;
	// Mode, less-than limit, greater-than limit, result word and expected flag.
	localparam awc_case_s CASES [15] = '{
		'{1'b0, 16'h2000, 16'h1000, 16'h1001, 1'b1}, '{1'b0, 16'h2000, 16'h1000, 16'h1000, 1'b0},
		'{1'b0, 16'h2000, 16'h1000, 16'h2000, 1'b0}, '{1'b0, 16'h2000, 16'h1000, 16'h1fff, 1'b1},
		'{1'b0, 16'h1000, 16'h2000, 16'h2001, 1'b1}, '{1'b0, 16'h1000, 16'h2000, 16'h0fff, 1'b1},
		'{1'b0, 16'h1000, 16'h2000, 16'h1800, 1'b0}, '{1'b0, 16'h1000, 16'h2000, 16'hffff, 1'b1},
		'{1'b0, 16'h1000, 16'h2000, 16'h0000, 1'b1}, '{1'b1, 16'h1000, 16'hffff, 16'h0000, 1'b1},
		'{1'b1, 16'h1000, 16'hffff, 16'hffff, 1'b0}, '{1'b1, 16'h1000, 16'hffff, 16'h8000, 1'b0},
		'{1'b1, 16'hffff, 16'h1000, 16'h8000, 1'b1}, '{1'b1, 16'hffff, 16'h1000, 16'h7fff, 1'b1},
		'{1'b1, 16'hffff, 16'h1000, 16'h0000, 1'b0}};
	logic core_clk = 1'b0, rst_b = 1'b0, start = 1'b0; // Clock, reset, conversion launch.
	logic [15:0] word = 16'h0000; // Word for the next conversion.
	awc_result_s result; // Model to design strobe.
	logic [11:0] awaddr = 12'h000, araddr = 12'h000; // Bus byte addresses.
	logic [31:0] wdata = 32'h0, rdata; // Bus data.
	logic [3:0] wstrb = 4'h0; // Byte strobes.
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // Master side.
	logic awready, wready, bvalid, arready, rvalid, irq; // Slave side.
	logic [1:0] bresp, rresp; // Response codes.
	int n_errors = 0, comparisons = 0; // Verdict counters.
	always #50 core_clk = ~core_clk;
	awc_conv_model awc_conv_model_i (.core_clk(core_clk), .rst_b(rst_b), .start(start), .word(word), .result(result));
	awc_window awc_window_i (.core_clk(core_clk), .rst_b(rst_b), .result(result), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
	// Counts every comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk
	// One write to word index a; address and data are offered together, each released once taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = AWC_RESP_OKAY);
		logic aw_open;
		logic w_open;
		@(posedge core_clk);
		awaddr <= {2'b00, a, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_open = 1'b1;
		w_open = 1'b1;
		while (aw_open || w_open) begin
			@(posedge core_clk);
			if (aw_open && awready === 1'b1) begin
				aw_open = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_open && wready === 1'b1) begin
				w_open = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, e);
	endtask : wr
	// One read; rready stays high until the data is sampled.
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = AWC_RESP_OKAY);
		@(posedge core_clk);
		araddr <= {2'b00, a, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge core_clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, x);
		chk(rresp, e);
	endtask : rd
	// One conversion; returns two edges after the strobe so flag and interrupt have settled.
	task automatic conv(input logic [15:0] d);
		@(posedge core_clk);
		start <= 1'b1;
		word <= d;
		@(posedge core_clk);
		start <= 1'b0;
		do @(posedge core_clk); while (result.eoc !== 1'b1);
		repeat (2) @(posedge core_clk);
	endtask : conv
	// Single place where the run ends.
	task automatic tally_and_finish();
		if (n_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// A hang is cut short well beyond the roughly thousand cycles the tests need.
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		tally_and_finish();
	end
	// Main sequence.
	initial begin
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(AWC_IDX_LT_HI, 32'h0);
		rd(AWC_IDX_LT_LO, 32'h0);
		rd(AWC_IDX_GT_HI, 32'hff);
		rd(AWC_IDX_GT_LO, 32'hff);
		wr(AWC_IDX_IRQ_EN, 8'h01);
		conv(16'hffff);
		rd(AWC_IDX_CTRL, 32'h0);
		foreach (CASES[i]) begin
			wr(AWC_IDX_LT_HI, CASES[i].lt[15:8]);
			wr(AWC_IDX_LT_LO, CASES[i].lt[7:0]);
			wr(AWC_IDX_GT_HI, CASES[i].gt[15:8]);
			wr(AWC_IDX_GT_LO, CASES[i].gt[7:0]);
			wr(AWC_IDX_CTRL, {6'h00, CASES[i].diff, 1'b0});
			conv(CASES[i].data);
			rd(AWC_IDX_CTRL, {30'h0, CASES[i].diff, CASES[i].hit});
			chk(irq, CASES[i].hit);
			rd(AWC_IDX_RESULT, CASES[i].data);
		end
		// Back-to-back results: a miss after a hit leaves the flag set.
		conv(16'h8000);
		conv(16'h0000);
		rd(AWC_IDX_CTRL, 32'h3);
		wr(AWC_IDX_CTRL, 8'h03);
		rd(AWC_IDX_CTRL, 32'h3);
		wr(AWC_IDX_IRQ_EN, 8'h00);
		chk(irq, 1'b0);
		wr(AWC_IDX_IRQ_CLR, 8'h01);
		rd(AWC_IDX_CTRL, 32'h2);
		rd(8'h00, 32'h0, AWC_RESP_SLVERR);
		wr(8'h00, 8'h00, AWC_RESP_SLVERR);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
